// file: cps_protection_sequencer.sv
// Purpose: Soft start, overcurrent, under/over-voltage and power-good sequencing.
// Assumes: Comparator flags come from analog sensing; supply_ok is the turn-on indication.
// Notes:   Registers are reached over AXI4-Lite; one level interrupt output.
`timescale 1ns/1ps

module cps_protection_sequencer #(
  parameter logic [cps_pkg::MV_W-1:0] VREF_BASE_MV = 12'h384,
  parameter logic [cps_pkg::MV_W-1:0] VREF_STEP_MV = 12'h064,
  parameter logic [cps_pkg::MV_W-1:0] EXT_REF_MV   = 12'h3E8
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // Supply and inhibit
  input  wire logic                 supply_ok,
  input  wire logic                 inhibit_input,
  // Analog comparator results and loop requests
  input  wire cps_pkg::cps_cmp_t    cmp_in,
  input  wire logic [1:0]           hs_request,
  // Gate drive and analog controls
  output cps_pkg::cps_gate_t        gate_out,
  output logic [cps_pkg::RAMP_W-1:0] ramp_reference,
  output logic                      droop_current_en,
  // Status pins
  output logic                      output_ok_indicator_o,
  output logic                      output_ok_indicator_oe,
  output logic                      fault_indicator_pin,
  output logic                      irq,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  localparam int unsigned PROD_W = cps_pkg::RAMP_W + cps_pkg::MV_W;

  cps_pkg::cps_cmp_t              cmp_s;
  cps_pkg::cps_state_t            state_q;
  logic [cps_pkg::CNT_W-1:0]      osc_cnt_q;
  logic [cps_pkg::RAMP_W-1:0]     ramp_q;
  logic [cps_pkg::CNT_W:0]        uv_cnt_q;
  logic [1:0]                     hs_on_q;
  logic [4:0]                     ctrl_q;
  logic [cps_pkg::EV_W-1:0]       irq_stat_q;
  logic [cps_pkg::EV_W-1:0]       irq_mask_q;
  logic [1:0]                     ocp_prev_q;
  logic                           osc_tick;
  logic                           switching;
  logic                           uv_enable;
  logic                           uv_fault;
  logic                           ov_detect;
  logic                           ramp_done;
  logic [cps_pkg::CNT_W-1:0]      ton_limit;
  logic [cps_pkg::EV_W-1:0]       events;
  logic                           wr_go;
  logic                           rd_go;
  logic [cps_pkg::MV_W-1:0]       final_mv;

  // Level select to final reference in millivolts; the top code selects the external one.
  function automatic logic [cps_pkg::MV_W-1:0] vref_mv(input logic [cps_pkg::VSEL_W-1:0] code);
    logic [cps_pkg::MV_W-1:0] step;
    step = VREF_STEP_MV * {{(cps_pkg::MV_W-cps_pkg::VSEL_W){1'b0}}, code};
    if (&code) begin
      vref_mv = EXT_REF_MV;
    end else begin
      vref_mv = VREF_BASE_MV + step;
    end
  endfunction

  // Position within the switching period of a phase; phase 1 runs half a period later.
  function automatic logic [cps_pkg::CNT_W-1:0] phase_pos(input logic [cps_pkg::CNT_W-1:0] cnt,
                                                          input logic ph);
    logic [cps_pkg::CNT_W:0] sum;
    sum = {1'b0, cnt} + (ph ? (cps_pkg::CNT_W+1)'(cps_pkg::OSC_HALF) : '0);
    if (sum >= (cps_pkg::CNT_W+1)'(cps_pkg::OSC_PERIOD)) begin
      sum = sum - (cps_pkg::CNT_W+1)'(cps_pkg::OSC_PERIOD);
    end
    phase_pos = sum[cps_pkg::CNT_W-1:0];
  endfunction

  cps_sync #(
    .WIDTH ($bits(cps_pkg::cps_cmp_t))
  ) u_cmp_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in (cmp_in),
    .sync_out (cmp_s)
  );

  // Oscillator divider: one enable pulse per switching period.
  assign osc_tick = (osc_cnt_q == cps_pkg::CNT_W'(cps_pkg::OSC_PERIOD - 1));

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      osc_cnt_q <= '0;
    end else if (osc_tick) begin
      osc_cnt_q <= '0;
    end else begin
      osc_cnt_q <= osc_cnt_q + 1'b1;
    end
  end

  assign final_mv  = vref_mv(ctrl_q[cps_pkg::CTRL_VSEL_LSB +: cps_pkg::VSEL_W]);
  assign switching = (state_q == cps_pkg::ST_SOFT) || (state_q == cps_pkg::ST_RUN);
  assign ramp_done = (ramp_q == cps_pkg::RAMP_W'(cps_pkg::RAMP_STEPS - 1));
  // The ramped reference in mV is final_mv * ramp / 2048; compare without dividing.
  assign uv_enable = (state_q == cps_pkg::ST_RUN) ||
                     ((state_q == cps_pkg::ST_SOFT) &&
                      (PROD_W'(ramp_q) * PROD_W'(final_mv) >=
                       PROD_W'(cps_pkg::UV_EN_MV * cps_pkg::RAMP_STEPS)));
  assign uv_fault  = uv_cnt_q > (cps_pkg::CNT_W+1)'(cps_pkg::OSC_PERIOD);
  assign ov_detect = supply_ok && !inhibit_input && cmp_s.above_ov;

  // Sequencer state.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= cps_pkg::ST_OFF;
    end else if (!supply_ok) begin
      state_q <= cps_pkg::ST_OFF;
    end else begin
      case (state_q)
        cps_pkg::ST_OFF: begin
          if (ov_detect) begin
            state_q <= cps_pkg::ST_OVP;
          end else if (!inhibit_input && ctrl_q[cps_pkg::CTRL_ENABLE]) begin
            state_q <= cps_pkg::ST_SOFT;
          end
        end
        cps_pkg::ST_HICCUP: begin
          state_q <= inhibit_input ? cps_pkg::ST_OFF : cps_pkg::ST_SOFT;
        end
        cps_pkg::ST_SOFT, cps_pkg::ST_RUN: begin
          if (ov_detect) begin
            state_q <= cps_pkg::ST_OVP;
          end else if (inhibit_input || !ctrl_q[cps_pkg::CTRL_ENABLE]) begin
            state_q <= cps_pkg::ST_OFF;
          end else if (uv_fault) begin
            state_q <= cps_pkg::ST_HICCUP;
          end else if (state_q == cps_pkg::ST_SOFT && osc_tick && ramp_done) begin
            state_q <= cps_pkg::ST_RUN;
          end
        end
        cps_pkg::ST_OVP: begin
          state_q <= cps_pkg::ST_OVP;
        end
        default: begin
          state_q <= cps_pkg::ST_OFF;
        end
      endcase
    end
  end

  // Reference ramp: one step per oscillator period, restarted on every fresh start.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ramp_q <= '0;
    end else if (state_q != cps_pkg::ST_SOFT) begin
      ramp_q <= (state_q == cps_pkg::ST_RUN) ? ramp_q : '0;
    end else if (osc_tick && !ramp_done) begin
      ramp_q <= ramp_q + 1'b1;
    end
  end

  // Under-voltage persistence: the comparator threshold tracks the ramp output.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      uv_cnt_q <= '0;
    end else if (!uv_enable || !cmp_s.below_uv || inhibit_input || uv_fault) begin
      uv_cnt_q <= '0;
    end else begin
      uv_cnt_q <= uv_cnt_q + 1'b1;
    end
  end

  assign ton_limit = ctrl_q[cps_pkg::CTRL_FIXED] ? cps_pkg::CNT_W'(cps_pkg::TON_FIXED_CYC)
                                                 : cps_pkg::CNT_W'(cps_pkg::TON_DYN_CYC);

  // High-side on-time per phase, started only at that phase's period start.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      hs_on_q <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!switching || cmp_s.overcurrent_flag[i]) begin
          hs_on_q[i] <= 1'b0;
        end else if (phase_pos(osc_cnt_q, i[0]) == '0) begin
          hs_on_q[i] <= hs_request[i];
        end else if (!hs_request[i] || phase_pos(osc_cnt_q, i[0]) >= ton_limit) begin
          hs_on_q[i] <= 1'b0;
        end
      end
    end
  end

  // Gate drive, power-good and fault outputs.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      gate_out               <= '0;
      output_ok_indicator_oe <= 1'b1;
      fault_indicator_pin    <= 1'b0;
      droop_current_en       <= 1'b0;
    end else begin
      if (state_q == cps_pkg::ST_OVP && !inhibit_input) begin
        gate_out.high_side <= 2'h0;
        gate_out.low_side  <= 2'h3;
      end else if (switching && !inhibit_input) begin
        gate_out.high_side <= hs_on_q & ~cmp_s.overcurrent_flag;
        gate_out.low_side  <= ~hs_on_q | cmp_s.overcurrent_flag;
      end else begin
        gate_out <= '0;
      end
      output_ok_indicator_oe <= !(state_q == cps_pkg::ST_RUN && cmp_s.in_pg_window);
      fault_indicator_pin    <= (state_q == cps_pkg::ST_OVP);
      droop_current_en       <= switching && !cmp_s.current_sum_neg;
    end
  end

  assign output_ok_indicator_o = 1'b0;
  assign ramp_reference        = ramp_q;

  // Interrupt events.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ocp_prev_q <= '0;
    end else begin
      ocp_prev_q <= cmp_s.overcurrent_flag;
    end
  end

  assign events[cps_pkg::EV_UV]      = uv_fault && switching;
  assign events[cps_pkg::EV_OV]      = ov_detect && state_q != cps_pkg::ST_OVP;
  assign events[cps_pkg::EV_OC0]     = cmp_s.overcurrent_flag[0] && !ocp_prev_q[0];
  assign events[cps_pkg::EV_OC1]     = cmp_s.overcurrent_flag[1] && !ocp_prev_q[1];
  assign events[cps_pkg::EV_SS_DONE] = state_q == cps_pkg::ST_SOFT && osc_tick && ramp_done;

  // AXI4-Lite: write address and data are taken together, one transfer at a time.
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_go;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_q     <= cps_pkg::CTRL_RESET;
      irq_mask_q <= '0;
    end else if (wr_go && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == cps_pkg::ADDR_CTRL) begin
        ctrl_q <= s_axi_wdata[4:0];
      end
      if (s_axi_awaddr == cps_pkg::ADDR_IRQ_MASK) begin
        irq_mask_q <= s_axi_wdata[cps_pkg::EV_W-1:0];
      end
    end
  end

  // A new event wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_stat_q <= '0;
    end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == cps_pkg::ADDR_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~s_axi_wdata[cps_pkg::EV_W-1:0]) | events;
    end else begin
      irq_stat_q <= irq_stat_q | events;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cps_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (s_axi_awaddr == cps_pkg::ADDR_STATUS ||
                       s_axi_awaddr[7:4] != 4'h0 || s_axi_awaddr[1:0] != 2'h0) ?
                      cps_pkg::RESP_SLVERR : cps_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= cps_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= cps_pkg::RESP_OKAY;
      case (s_axi_araddr)
        cps_pkg::ADDR_CTRL:     s_axi_rdata <= {27'h0, ctrl_q};
        cps_pkg::ADDR_STATUS:   s_axi_rdata <= {8'h0, 5'h0, ramp_q, 1'b0, state_q,
                                                !output_ok_indicator_oe,
                                                fault_indicator_pin,
                                                cmp_s.overcurrent_flag};
        cps_pkg::ADDR_IRQ_STAT: s_axi_rdata <= {27'h0, irq_stat_q};
        cps_pkg::ADDR_IRQ_MASK: s_axi_rdata <= {27'h0, irq_mask_q};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= cps_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: cps_pkg.sv
// Purpose: Shared constants and carrier types of the converter protection sequencer.
// Assumes: 125 MHz clock; the internal oscillator is derived from it by an enable divider.
// Notes:   Percent thresholds live in the analog comparators; their values are listed here, unused by the logic.
package cps_pkg;

  // Clock and oscillator timing.
  localparam int unsigned CLK_FREQ_HZ   = 125000000;
  localparam int unsigned OSC_FREQ_HZ   = 150000;
  localparam int unsigned OSC_PERIOD    = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int unsigned OSC_HALF      = OSC_PERIOD / 2;
  localparam int unsigned TON_FIXED_PCT = 85;
  localparam int unsigned TON_DYN_PCT   = 80;
  localparam int unsigned TON_FIXED_CYC = OSC_PERIOD * TON_FIXED_PCT / 100;
  localparam int unsigned TON_DYN_CYC   = OSC_PERIOD * TON_DYN_PCT / 100;
  localparam int unsigned CNT_W         = 10;

  // Soft start ramp and under-voltage enable level.
  localparam int unsigned RAMP_STEPS    = 2048;
  localparam int unsigned RAMP_W        = 11;
  localparam int unsigned UV_EN_MV      = 600;
  localparam int unsigned MV_W          = 12;

  // Comparator thresholds, as documented for the analog side.
  localparam int unsigned UV_PCT        = 60;
  localparam int unsigned OV_PCT        = 115;
  localparam int unsigned PG_WIN_PCT    = 12;

  // Register map, byte addresses.
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0C;

  // Control register fields and reset value.
  localparam int unsigned CTRL_ENABLE   = 0;
  localparam int unsigned CTRL_FIXED    = 1;
  localparam int unsigned CTRL_VSEL_LSB = 2;
  localparam int unsigned VSEL_W        = 3;
  localparam logic [4:0] CTRL_RESET     = 5'h03;

  // Interrupt event bits.
  localparam int unsigned EV_UV         = 0;
  localparam int unsigned EV_OV         = 1;
  localparam int unsigned EV_OC0        = 2;
  localparam int unsigned EV_OC1        = 3;
  localparam int unsigned EV_SS_DONE    = 4;
  localparam int unsigned EV_W          = 5;

  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_HICCUP,
    ST_SOFT,
    ST_RUN,
    ST_OVP
  } cps_state_t;

  // Comparator results as they arrive from the analog sensing.
  typedef struct packed {
    logic [1:0] overcurrent_flag;
    logic       below_uv;
    logic       above_ov;
    logic       in_pg_window;
    logic       current_sum_neg;
  } cps_cmp_t;

  // Gate drive requests for both phases.
  typedef struct packed {
    logic [1:0] high_side;
    logic [1:0] low_side;
  } cps_gate_t;

endpackage

// file: cps_sync.sv
// Purpose: Two-flop synchroniser for a bundle of comparator levels.
// Assumes: Each bit is an independent level; no bundle coherence is promised.
// Notes:   Only the second stage may be read outside this module.
`timescale 1ns/1ps
module cps_sync #(
  parameter int unsigned WIDTH = 6
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stage1_q <= '0;
      sync_out <= '0;
    end else begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end

endmodule

// file: cps_protection_sequencer_asserts.sv
// Purpose: Port-level checks of the protection sequencer.
// Assumes: Comparator levels reach the gates three edges after they change.
// Notes:   Long counts such as the under-voltage filter are left to the bench.
`timescale 1ns/1ps
module cps_psq_chk (
  // Clock and reset
  input wire logic                       ref_clk,
  input wire logic                       reset_n,
  // Inputs
  input wire logic                       supply_ok,
  input wire logic                       inhibit_input,
  input wire cps_pkg::cps_cmp_t          cmp_in,
  input wire logic                       s_axi_bready,
  input wire logic                       s_axi_rready,
  // Outputs
  input wire cps_pkg::cps_gate_t         gate_out,
  input wire logic [cps_pkg::RAMP_W-1:0] ramp_reference,
  input wire logic                       droop_current_en,
  input wire logic                       output_ok_indicator_oe,
  input wire logic                       fault_indicator_pin,
  input wire logic                       s_axi_bvalid,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_rvalid,
  input wire logic [31:0]                s_axi_rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Four samples cover the synchroniser and the gate register.
  sequence oc0_held;
    (cmp_in.overcurrent_flag[0] && !inhibit_input) [*4];
  endsequence
  sequence ov_held;
    (cmp_in.above_ov && supply_ok && !inhibit_input) [*4];
  endsequence

  chk_oc_hs_off: assert property (oc0_held |-> !gate_out.high_side[0])
    else $error("high side on during overcurrent");
  chk_inhibit_gates: assert property (inhibit_input [*3] |-> gate_out == '0)
    else $error("gates driven under inhibit");
  chk_ovp_entry: assert property (ov_held |-> ##[0:2] fault_indicator_pin)
    else $error("over-voltage not latched");
  chk_ovp_gates: assert property ((fault_indicator_pin && !inhibit_input) [*2]
    |-> {gate_out.high_side, gate_out.low_side} == 4'h3)
    else $error("latched gates wrong");
  chk_ovp_sticky: assert property (fault_indicator_pin && supply_ok |=> fault_indicator_pin)
    else $error("latch left without supply loss");
  chk_pg_window: assert property (!output_ok_indicator_oe |-> $past(cmp_in.in_pg_window, 3))
    else $error("power good outside window");
  chk_pg_soft: assert property (!output_ok_indicator_oe |-> ramp_reference == 11'h7FF)
    else $error("power good during soft start");
  chk_droop_neg: assert property (cmp_in.current_sum_neg [*4] |-> !droop_current_en)
    else $error("droop on for negative current");
  chk_ramp_step: assert property ($changed(ramp_reference)
    |-> ramp_reference == $past(ramp_reference) + 1'b1 || ramp_reference == '0)
    else $error("ramp jumped");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

bind cps_protection_sequencer cps_psq_chk u_cps_psq_chk (
  .ref_clk, .reset_n, .supply_ok, .inhibit_input, .cmp_in, .s_axi_bready, .s_axi_rready,
  .gate_out, .ramp_reference, .droop_current_en, .output_ok_indicator_oe,
  .fault_indicator_pin, .s_axi_bvalid, .s_axi_bresp, .s_axi_rvalid, .s_axi_rdata
);

// file: cps_plant.sv
// Purpose: Behavioural power stage and output sensing seen by the sequencer.
// Assumes: The bench sets load and fault knobs after a clock edge.
// Notes:   The output only sits in the window while some gate is driven on.
`timescale 1ns/1ps
module cps_plant (
  // Gates
  input  wire cps_pkg::cps_gate_t gate_out,
  // Knobs
  input  wire logic [1:0]         oc_load,
  input  wire logic               out_low,
  input  wire logic               out_high,
  input  wire logic               neg_load,
  // Comparator levels
  output cps_pkg::cps_cmp_t       cmp_in
);
  assign cmp_in.overcurrent_flag = oc_load;
  assign cmp_in.below_uv         = out_low;
  assign cmp_in.above_ov         = out_high;
  assign cmp_in.in_pg_window     = !out_low && !out_high && (|gate_out);
  assign cmp_in.current_sum_neg  = neg_load;
endmodule

// file: cps_protection_sequencer_tb.sv
// Purpose: Self-checking bench of the protection sequencer.
// Assumes: Soft start is far longer than the run, so only its start is seen.
// Notes:   Under-voltage hiccup needs the ramp near 0.6 V and is not exercised; only no early trip is checked.
`timescale 1ns/1ps
module cps_protection_sequencer_tb;
  logic                       ref_clk, reset_n, supply_ok, inhibit_input;
  logic [1:0]                 hs_request, oc_load, s_axi_bresp, s_axi_rresp, rs;
  logic                       out_low, out_high, neg_load;
  cps_pkg::cps_cmp_t          cmp_in;
  cps_pkg::cps_gate_t         gate_out;
  logic [cps_pkg::RAMP_W-1:0] ramp_reference, r0;
  logic                       droop_current_en, pg_o, pg_oe, fault_indicator_pin, irq;
  logic [7:0]                 s_axi_awaddr, s_axi_araddr;
  logic [31:0]                s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]                 s_axi_wstrb;
  logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                       s_axi_rvalid, s_axi_rready;
  int                         n_fail, total_checks;

  cps_protection_sequencer u_cps_protection_sequencer (
    .ref_clk, .reset_n, .supply_ok, .inhibit_input, .cmp_in, .hs_request, .gate_out,
    .ramp_reference, .droop_current_en, .output_ok_indicator_o(pg_o),
    .output_ok_indicator_oe(pg_oe), .fault_indicator_pin, .irq, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  cps_plant u_cps_plant (.gate_out, .oc_load, .out_low, .out_high, .neg_load, .cmp_in);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic t_regs;
    axi_rd(cps_pkg::ADDR_CTRL, rd, rs);
    check(rd, {27'h0, cps_pkg::CTRL_RESET}, "control reset value");
    axi_rd(cps_pkg::ADDR_IRQ_MASK, rd, rs);
    check(rd, 32'h0, "mask reset value");
    axi_rd(8'h10, rd, rs);
    check({rd[29:0], rs}, {30'h0, cps_pkg::RESP_SLVERR}, "unmapped read");
    axi_wr(cps_pkg::ADDR_CTRL, 32'h1F, rs);
    check(rs, cps_pkg::RESP_OKAY, "control write response");
    axi_rd(cps_pkg::ADDR_CTRL, rd, rs);
    check(rd, 32'h1F, "control write with level select");
    axi_wr(cps_pkg::ADDR_CTRL, {27'h0, cps_pkg::CTRL_RESET}, rs);
    axi_wr(cps_pkg::ADDR_STATUS, 32'hFF, rs);
    check(rs, cps_pkg::RESP_SLVERR, "status write");
    $display("test regs done");
  endtask

  task automatic t_soft;
    axi_rd(cps_pkg::ADDR_STATUS, rd, rs);
    check(rd[6:4], 3'h2, "not in soft start");
    r0 = ramp_reference;
    cyc(cps_pkg::OSC_PERIOD);
    check(32'(ramp_reference), 32'(r0) + 32'h1, "ramp step");
    check(pg_oe, 1'b1, "power good released early");
    check(pg_o, 1'b0, "power good pin driven high");
    $display("test soft start done");
  endtask

  task automatic measure(input int exp);
    int n;
    n = 0;
    while (gate_out.high_side[0] !== 1'b0) @(posedge ref_clk);
    while (gate_out.high_side[0] !== 1'b1) @(posedge ref_clk);
    while (gate_out.high_side[0] === 1'b1) begin
      n++;
      @(posedge ref_clk);
    end
    check(n, exp, "on-time limit");
  endtask

  task automatic t_ontime;
    hs_request <= 2'b11;
    measure(cps_pkg::TON_FIXED_CYC);
    axi_wr(cps_pkg::ADDR_CTRL, 32'h1, rs);
    measure(cps_pkg::TON_DYN_CYC);
    axi_wr(cps_pkg::ADDR_CTRL, 32'h3, rs);
    $display("test on-time done");
  endtask

  task automatic t_oc;
    int n;
    axi_wr(cps_pkg::ADDR_IRQ_MASK, 32'h4, rs);
    oc_load <= 2'b01;
    cyc(5);
    check({gate_out.high_side[0], gate_out.low_side[0]}, 2'b01, "overcurrent gates");
    check(irq, 1'b1, "overcurrent irq");
    axi_wr(cps_pkg::ADDR_IRQ_STAT, 32'h4, rs);
    check(irq, 1'b0, "irq clear");
    cyc(cps_pkg::OSC_PERIOD);
    check(gate_out.high_side[0], 1'b0, "cycle not skipped");
    oc_load <= 2'b00;
    n = 0;
    while (gate_out.high_side[0] !== 1'b1 && n < cps_pkg::OSC_PERIOD + 8) begin
      n++;
      @(posedge ref_clk);
    end
    check(gate_out.high_side[0], 1'b1, "no resume");
    axi_wr(cps_pkg::ADDR_IRQ_MASK, 32'h0, rs);
    $display("test overcurrent done");
  endtask

  task automatic t_misc;
    neg_load <= 1'b1;
    cyc(5);
    check(droop_current_en, 1'b0, "droop negative");
    neg_load <= 1'b0;
    out_low <= 1'b1;
    cyc(cps_pkg::OSC_PERIOD + 20);
    check(droop_current_en, 1'b1, "droop positive");
    axi_rd(cps_pkg::ADDR_STATUS, rd, rs);
    check(rd[6:4], 3'h2, "early under-voltage trip");
    out_low <= 1'b0;
    inhibit_input <= 1'b1;
    cyc(4);
    check({28'h0, gate_out}, 32'h0, "inhibit gates");
    inhibit_input <= 1'b0;
    $display("test droop uv inhibit done");
  endtask

  task automatic t_ovp;
    out_high <= 1'b1;
    cyc(6);
    check(fault_indicator_pin, 1'b1, "over-voltage fault");
    check({28'h0, gate_out}, 32'h3, "crowbar gates");
    out_high <= 1'b0;
    inhibit_input <= 1'b1;
    cyc(10);
    inhibit_input <= 1'b0;
    cyc(4);
    check(fault_indicator_pin, 1'b1, "latch lost");
    supply_ok <= 1'b0;
    cyc(4);
    check(fault_indicator_pin, 1'b0, "latch kept off supply");
    supply_ok <= 1'b1;
    $display("test over-voltage done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    cyc(60000);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    {reset_n, inhibit_input, hs_request, oc_load, out_low, out_high, neg_load} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    supply_ok = 1'b1;
    s_axi_wstrb = 4'hF;
    n_fail = 0;
    total_checks = 0;
    cyc(4);
    reset_n <= 1'b1;
    cyc(2);
    t_regs();
    t_soft();
    t_ontime();
    t_oc();
    t_misc();
    t_ovp();
    tally_and_finish();
  end
endmodule
